/* File: logic/saw_loop_ctl.sv */
// mode control of one pid loop driven by its setpoint's on and remote flags
// assumes flags come from flip-flops in the same clock domain
`timescale 1ns/1ns
module saw_loop_ctl (
    input  logic clk,
    input  logic rst_n,
    input  logic ce,
    input  logic pid_mode,
    input  logic remote,
    input  logic on_flag,
    output logic manual,
    output logic zero_hold
);

    saw_pkg::saw_loop_e state_r;
    saw_pkg::saw_loop_e state_nxt;

    always_comb begin
        if (!pid_mode || !remote) begin
            state_nxt = saw_pkg::LOOP_AUTO;
        end else if (on_flag) begin
            state_nxt = saw_pkg::LOOP_MANUAL;
        end else begin
            state_nxt = saw_pkg::LOOP_OFF;
        end
    end

    // starts in auto; a cleared remote flag always falls back to auto
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r   <= saw_pkg::LOOP_AUTO;
            manual    <= 1'b0;
            zero_hold <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            unique case (state_nxt)
                saw_pkg::LOOP_AUTO: begin
                    manual    <= 1'b0;
                    zero_hold <= 1'b0;
                end
                saw_pkg::LOOP_MANUAL: begin
                    manual    <= 1'b1;
                    zero_hold <= 1'b0;
                end
                saw_pkg::LOOP_OFF: begin
                    manual    <= 1'b0;
                    zero_hold <= 1'b1;
                end
                default: begin
                    manual    <= 1'b0;
                    zero_hold <= 1'b0;
                end
            endcase
        end
    end

    reset_auto_a: assert property (@(posedge clk)
        !rst_n |=> (!manual && !zero_hold && state_r == saw_pkg::LOOP_AUTO))
        else $error("loop not in auto after reset");

    exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(manual && zero_hold))
        else $error("loop both manual and off");

endmodule // saw_loop_ctl

/* File: logic/saw_pkg.sv */
// constants shared by the setpoint alarm register views and the loop mode control
// assumes register numbers arrive as plain 16-bit register indices
package saw_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_FULL      = 16'h00EF;
    localparam logic [15:0] ADDR_LOW_WORD  = 16'h119B;
    localparam logic [15:0] ADDR_HIGH_WORD = 16'h119C;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int NUM_SETPOINTS = 16;
    localparam int NUM_PID_LOOPS = 5;
    localparam int HALF_COUNT    = 8;
    localparam int WORD_ON_POS   = 0;
    localparam int WORD_RMT_POS  = 8;
    localparam int FULL_ON_POS   = 0;
    localparam int FULL_RMT_POS  = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ON_RESET     = 16'h0000;
    localparam logic [15:0] REMOTE_RESET = 16'h0000;

    // ------------------------------------------------------------
    // loop modes, gray along auto -> manual -> off
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_AUTO   = 2'h0,
        LOOP_MANUAL = 2'h1,
        LOOP_OFF    = 2'h3
    } saw_loop_e;

endpackage

/* File: logic/saw_top.sv */
// setpoint alarm state with a 32-bit view and two 16-bit word views
// assumes one register access per cycle on a synchronous register port
//
// How it works
// - two 16-bit registers mirror the 32-bit alarm register so it can be accessed as two words.
// - the low word holds only the on and remote flags of setpoints one to eight.
// - low-word bits 0 to 7 read the on state of setpoints one to eight and, on write, set it for those in remote mode.
// - low-word bits 8 to 15 select remote mode for setpoints one to eight, one meaning remote.
// - for setpoints one to five in pid mode, a set remote bit with the on bit set moves the loop from auto to manual.
// - clearing the remote bit of a pid setpoint returns its loop to auto.
// - remote bits of setpoints six to eight only pick normal or remote, with no loop effect.
// - the high word holds the on and remote flags of setpoints nine to sixteen.
// - high-word bits 0 to 6 read the on state of setpoints nine to fifteen and set it for those in remote mode.
// - high-word bit 7 reads the on state of setpoint sixteen and sets it when that setpoint is in remote mode.
// - high-word bits 8 to 15 select remote mode for setpoints nine to sixteen.
// - a pid setpoint with remote set and on cleared has its loop off and working values zeroed.
// - pid loops come up in auto mode after reset.
`timescale 1ns/1ns
module saw_top #(
    parameter int NSP  = saw_pkg::NUM_SETPOINTS,
    parameter int NPID = saw_pkg::NUM_PID_LOOPS
) (
    input  logic            CLOCK,
    input  logic            RESETN,
    input  logic            CLOCK_EN,
    input  logic [15:0]     REG_ADDR,
    input  logic            REG_WR,
    input  logic            REG_RD,
    input  logic [31:0]     REG_WDATA,
    output logic [31:0]     REG_RDATA,
    output logic            REG_ACK,
    output logic            REG_FAULT,
    input  logic [NSP-1:0]  SP_EVAL_ON,
    input  logic [NPID-1:0] PID_MODE,
    output logic [NSP-1:0]  SETPOINT_ON,
    output logic [NSP-1:0]  SETPOINT_REMOTE,
    output logic [NPID-1:0] LOOP_MANUAL,
    output logic [NPID-1:0] LOOP_ZERO
);

    localparam int H = saw_pkg::HALF_COUNT;

    // ------------------------------------------------------------
    // shared alarm state
    // ------------------------------------------------------------
    logic [NSP-1:0] on_r;
    logic [NSP-1:0] on_nxt;
    logic [NSP-1:0] remote_r;
    logic [NSP-1:0] remote_nxt;
    logic [NSP-1:0] on_wmask;
    logic [NSP-1:0] on_wval;
    logic [NSP-1:0] rmt_wmask;
    logic [NSP-1:0] rmt_wval;
    logic [NSP-1:0] on_sw;
    logic           hit_full;
    logic           hit_low;
    logic           hit_high;
    logic           hit_any;
    logic [31:0]    rd_data;

    assign hit_full = (REG_ADDR == saw_pkg::ADDR_FULL);
    assign hit_low  = (REG_ADDR == saw_pkg::ADDR_LOW_WORD);
    assign hit_high = (REG_ADDR == saw_pkg::ADDR_HIGH_WORD);
    assign hit_any  = hit_full || hit_low || hit_high;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    always_comb begin
        on_wmask  = '0;
        rmt_wmask = '0;
        on_wval   = '0;
        rmt_wval  = '0;
        if (REG_WR && hit_full) begin
            on_wmask  = '1;
            rmt_wmask = '1;
            on_wval   = REG_WDATA[saw_pkg::FULL_ON_POS +: NSP];
            rmt_wval  = REG_WDATA[saw_pkg::FULL_RMT_POS +: NSP];
        end else if (REG_WR && hit_low) begin
            on_wmask[0 +: H]  = '1;
            rmt_wmask[0 +: H] = '1;
            on_wval[0 +: H]   = REG_WDATA[saw_pkg::WORD_ON_POS +: H];
            rmt_wval[0 +: H]  = REG_WDATA[saw_pkg::WORD_RMT_POS +: H];
        end else if (REG_WR && hit_high) begin
            on_wmask[H +: H]  = '1;
            rmt_wmask[H +: H] = '1;
            on_wval[H +: H]   = REG_WDATA[saw_pkg::WORD_ON_POS +: H];
            rmt_wval[H +: H]  = REG_WDATA[saw_pkg::WORD_RMT_POS +: H];
        end
    end

    // in normal mode the alarm evaluator owns the on flag, so a write there
    // is overridden the same cycle; only remote setpoints keep written values
    assign remote_nxt = (remote_r & ~rmt_wmask) | (rmt_wval & rmt_wmask);
    assign on_sw      = (on_r & ~on_wmask) | (on_wval & on_wmask);
    assign on_nxt     = (remote_nxt & on_sw) | (~remote_nxt & SP_EVAL_ON);

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            remote_r <= saw_pkg::REMOTE_RESET;
        end else if (CLOCK_EN) begin
            remote_r <= remote_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            on_r <= saw_pkg::ON_RESET;
        end else if (CLOCK_EN) begin
            on_r <= on_nxt;
        end
    end

    assign SETPOINT_ON     = on_r;
    assign SETPOINT_REMOTE = remote_r;

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_full) begin
            rd_data = {remote_r, on_r};
        end else if (hit_low) begin
            rd_data = {16'h0000, remote_r[0 +: H], on_r[0 +: H]};
        end else if (hit_high) begin
            rd_data = {16'h0000, remote_r[H +: H], on_r[H +: H]};
        end
    end

    // unmapped numbers read zero, ignore writes and raise a fault pulse
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            REG_RDATA <= 32'h0000_0000;
            REG_ACK   <= 1'b0;
            REG_FAULT <= 1'b0;
        end else if (CLOCK_EN) begin
            if (REG_RD) begin
                REG_RDATA <= rd_data;
            end
            REG_ACK   <= (REG_RD || REG_WR) && hit_any;
            REG_FAULT <= (REG_RD || REG_WR) && !hit_any;
        end
    end

    // ------------------------------------------------------------
    // pid loop mode, setpoints one to five only
    // ------------------------------------------------------------
    // loops watch the registered flags, so mode lags a write by one cycle
    for (genvar k = 0; k < NPID; k++) begin : g_loop
        saw_loop_ctl u_loop (
            .clk       (CLOCK),
            .rst_n     (RESETN),
            .ce        (CLOCK_EN),
            .pid_mode  (PID_MODE[k]),
            .remote    (remote_r[k]),
            .on_flag   (on_r[k]),
            .manual    (LOOP_MANUAL[k]),
            .zero_hold (LOOP_ZERO[k])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    low_read_a: assert property (
        CLOCK_EN && REG_RD && hit_low |=>
            REG_RDATA == {16'h0000, $past(remote_r[7:0]), $past(on_r[7:0])})
        else $error("low word read mismatch");

    high_read_a: assert property (
        CLOCK_EN && REG_RD && hit_high |=>
            REG_RDATA == {16'h0000, $past(remote_r[15:8]), $past(on_r[15:8])})
        else $error("high word read mismatch");

    low_write_half_a: assert property (
        CLOCK_EN && REG_WR && hit_low |=>
            remote_r[7:0] == $past(REG_WDATA[15:8]) && remote_r[15:8] == $past(remote_r[15:8]))
        else $error("low word write touched wrong half");

    high_write_a: assert property (
        CLOCK_EN && REG_WR && hit_high && REG_WDATA[14] |=>
            remote_r[14] && on_r[14] == $past(REG_WDATA[6]) && on_r[7:0] == $past(on_nxt[7:0]))
        else $error("high word write not applied");

    remote_on_a: assert property (
        CLOCK_EN && REG_WR && hit_low && REG_WDATA[8] |=> on_r[0] == $past(REG_WDATA[0]))
        else $error("remote on flag not written");

    normal_follow_a: assert property (
        CLOCK_EN |=> remote_r[9] || on_r[9] == $past(SP_EVAL_ON[9]))
        else $error("normal setpoint not following evaluator");

    manual_entry_a: assert property (
        CLOCK_EN && PID_MODE[0] && remote_r[0] && on_r[0] |=> LOOP_MANUAL[0] && !LOOP_ZERO[0])
        else $error("loop did not enter manual");

    auto_return_a: assert property (
        CLOCK_EN && !remote_r[1] |=> !LOOP_MANUAL[1] && !LOOP_ZERO[1])
        else $error("loop did not return to auto");

    off_zero_a: assert property (
        CLOCK_EN && PID_MODE[2] && remote_r[2] && !on_r[2] |=> LOOP_ZERO[2] && !LOOP_MANUAL[2])
        else $error("loop not turned off");

    map_ack_a: assert property (
        CLOCK_EN && (REG_RD || REG_WR) |=> REG_ACK == $past(hit_any) && REG_FAULT != REG_ACK)
        else $error("access answer wrong");

    full_read_a: assert property (
        CLOCK_EN && REG_RD && hit_full |=>
            REG_RDATA == {$past(remote_r), $past(on_r)})
        else $error("full view read mismatch");

    fault_read_a: assert property (
        CLOCK_EN && REG_RD && !hit_any |=> REG_RDATA == 32'h0000_0000 && REG_FAULT)
        else $error("unmapped read not zero");

    frozen_hold_a: assert property (
        !CLOCK_EN |=> $stable(on_r) && $stable(remote_r) && $stable(REG_ACK))
        else $error("state moved while clock enable low");

    high_half_a: assert property (
        CLOCK_EN && REG_WR && hit_high |=> remote_r[7:0] == $past(remote_r[7:0]))
        else $error("high word write touched low half");

endmodule // saw_top

/* File: tb/saw_master.sv */
// register master model that issues reads and writes to the alarm views
// assumes the device answers on the taking edge, before the next falling edge
`timescale 1ns/1ns
module saw_master (
    input  logic        CLOCK,
    input  logic        REG_ACK,
    input  logic        REG_FAULT,
    input  logic [31:0] REG_RDATA,
    output logic        REG_WR,
    output logic        REG_RD,
    output logic [15:0] REG_ADDR,
    output logic [31:0] REG_WDATA
);
    initial begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 16'h0000;
        REG_WDATA = 32'h00000000;
    end

    // one access, held across the taking edge; answer sampled a cycle later
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] r);
        @(negedge CLOCK);
        REG_WR = wr;
        REG_RD = ~wr;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge CLOCK);
        q = REG_RDATA;
        r = {REG_FAULT, REG_ACK};
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        // released lines show a changed pattern so stale values are not relied on
        REG_ADDR = ~a;
        REG_WDATA = ~d;
    endtask
endmodule // saw_master

/* File: tb/saw_top_tb.sv */
// self-checking bench for the alarm register views and loop modes
// assumes the master model sits on the register port
`timescale 1ns/1ns
module saw_top_tb;
    logic        CLOCK, RESETN, CLOCK_EN, REG_WR, REG_RD, REG_ACK, REG_FAULT;
    logic [15:0] REG_ADDR, SP_EVAL_ON, SETPOINT_ON, SETPOINT_REMOTE, m_on, m_rmt;
    logic [31:0] REG_WDATA, REG_RDATA, q, d;
    logic [4:0]  PID_MODE, LOOP_MANUAL, LOOP_ZERO;
    logic [1:0]  r;
    logic [15:0] views [3];
    integer      errors, samples_checked, seed, cycles, i, v;

    saw_top #(.NSP(16), .NPID(5)) uut (.CLOCK(CLOCK), .RESETN(RESETN), .CLOCK_EN(CLOCK_EN),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_FAULT(REG_FAULT),
        .SP_EVAL_ON(SP_EVAL_ON), .PID_MODE(PID_MODE), .SETPOINT_ON(SETPOINT_ON),
        .SETPOINT_REMOTE(SETPOINT_REMOTE), .LOOP_MANUAL(LOOP_MANUAL), .LOOP_ZERO(LOOP_ZERO));
    saw_master master (.CLOCK(CLOCK), .REG_ACK(REG_ACK), .REG_FAULT(REG_FAULT),
        .REG_RDATA(REG_RDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA));

    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize;
        $display("counts: %0d checked, %0d errors", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] view(input logic [15:0] a);
        case (a)
            saw_pkg::ADDR_FULL:      return {m_rmt, m_on};
            saw_pkg::ADDR_LOW_WORD:  return {16'h0000, m_rmt[7:0], m_on[7:0]};
            saw_pkg::ADDR_HIGH_WORD: return {16'h0000, m_rmt[15:8], m_on[15:8]};
            default:                 return 32'h00000000;
        endcase
    endfunction

    // the full value goes out; the model keeps on bits only where remote is set,
    // since the idle evaluator overrides on bits of normal setpoints
    task automatic mwr(input logic [15:0] a, input logic [31:0] x);
        logic [31:0] y;
        y = x;
        if (a == saw_pkg::ADDR_FULL) begin
            y[15:0] = y[15:0] & y[31:16];
            {m_rmt, m_on} = y;
        end else begin
            y[7:0] = y[7:0] & y[15:8];
            if (a == saw_pkg::ADDR_LOW_WORD) {m_rmt[7:0], m_on[7:0]} = y[15:0];
            else {m_rmt[15:8], m_on[15:8]} = y[15:0];
        end
        master.xfer(1'b1, a, x, q, r);
        chk(32'(r), 32'h1, "write ack");
    endtask

    task automatic chkall;
        for (int k = 0; k < 3; k++) begin
            master.xfer(1'b0, views[k], 32'h0, q, r);
            chk(32'(r), 32'h1, "read ack");
            chk(q, view(views[k]), "view data");
        end
        chk({SETPOINT_REMOTE, SETPOINT_ON}, {m_rmt, m_on}, "flags");
        chk(32'(LOOP_MANUAL), 32'(PID_MODE & m_rmt[4:0] & m_on[4:0]), "manual");
        chk(32'(LOOP_ZERO), 32'(PID_MODE & m_rmt[4:0] & ~m_on[4:0]), "zero");
    endtask

    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        seed = 32'hF7CC3B9B;
        views = '{saw_pkg::ADDR_FULL, saw_pkg::ADDR_LOW_WORD, saw_pkg::ADDR_HIGH_WORD};
        RESETN = 1'b0;
        CLOCK_EN = 1'b1;
        SP_EVAL_ON = 16'h0000;
        PID_MODE = 5'h1F;
        m_on = saw_pkg::ON_RESET;
        m_rmt = saw_pkg::REMOTE_RESET;
        repeat (5) @(negedge CLOCK);
        RESETN = 1'b1;
        chkall;
        $display("reset test done");
        mwr(saw_pkg::ADDR_LOW_WORD, 32'h0000FFFF);
        mwr(saw_pkg::ADDR_HIGH_WORD, 32'h00008080);
        chkall;
        mwr(saw_pkg::ADDR_LOW_WORD, 32'h00001F00);
        chkall;
        mwr(saw_pkg::ADDR_LOW_WORD, 32'h00000000);
        chkall;
        $display("corner test done");
        for (i = 0; i < 40; i++) begin
            PID_MODE = 5'($random(seed));
            d = $random(seed);
            v = {$random(seed)} % 3;
            mwr(views[v], d);
            chkall;
        end
        $display("random test done");
        master.xfer(1'b1, 16'h1234, 32'hFFFFFFFF, q, r);
        chk(32'(r), 32'h2, "unmapped write");
        master.xfer(1'b0, 16'h1234, 32'h0, q, r);
        chk(32'(r), 32'h2, "unmapped read");
        chk(q, 32'h0, "unmapped data");
        // let the fault pulse end before freezing, or it would stand frozen
        @(negedge CLOCK);
        CLOCK_EN = 1'b0;
        master.xfer(1'b1, saw_pkg::ADDR_LOW_WORD, 32'h0000FFFF, q, r);
        chk(32'(r), 32'h0, "frozen write");
        CLOCK_EN = 1'b1;
        chkall;
        $display("refusal test done");
        mwr(saw_pkg::ADDR_FULL, 32'h0);
        SP_EVAL_ON = 16'($random(seed));
        repeat (2) @(negedge CLOCK);
        chk(32'(SETPOINT_ON), 32'(SP_EVAL_ON), "evaluator on");
        $display("evaluator test done");
        summarize;
    end
endmodule // saw_top_tb
